// File: hw/sei_status_event_irq.sv
// Overview of operation
// - Status change to event condition sets event
// - Events stay set until host clears
// - Flags live; events mark change since read
// - Any driver flag rising: one event
// - Three events for velocity phase codes
// - Driver reply event has no live flag
// - Reading events clears unprotected event bits
// - Protect mask bits survive event read
// - Writing one clears that event bit
// - 27 events; select mask feeds status
// - Status in top bits, lowest eight
// - Interrupt is OR of enabled events
// - Events set in the read-clear cycle survive it
// - Interrupt active low unless polarity set
// - Weak drive modes for wired-OR/AND
`timescale 1ns/100ps
`default_nettype none
module sei_status_event_irq (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SPI_SCK,
    input wire logic SPI_CS_N,
    input wire logic SPI_SDI,
    input wire logic [sei_pkg::REG_W-1:0] COND_FLAGS,
    input wire logic DRV_REPLY_READY,
    output logic SPI_SDO,
    output logic SPI_SDO_OE_N,
    output logic IRQ_O,
    output logic IRQ_OE_N,
    output logic IRQ_WEAK_EN,
    output logic [sei_pkg::REG_W-1:0] GLOBAL_CONFIG
);
    import sei_pkg::*;

    logic [REG_W-1:0] gcfg_q;
    logic [REG_W-1:0] sel_q;
    logic [REG_W-1:0] prot_q;
    logic [REG_W-1:0] ien_q;
    logic [REG_W-1:0] ev_q;
    logic [REG_W-1:0] ev_d;
    logic [REG_W-1:0] flags_prev_q;
    logic [REG_W-1:0] rd_hold_q;
    logic [REG_W-1:0] rd_val;
    logic [REG_W-1:0] trig;
    logic [REG_W-1:0] clr;
    logic [SPI_BITS-1:0] tx_q;
    logic [SPI_BITS-1:0] rx_word;
    logic rx_toggle;
    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_seen_q;
    logic csn_s1_q;
    logic csn_s2_q;
    logic frame_ev;
    logic is_wr;
    logic [ADR_W-1:0] addr;
    logic [REG_W-1:0] rx_data;
    logic irq_any;
    logic irq_pol;
    logic irq_weak;
    logic irq_wand;
    logic irq_o_q;
    logic irq_oe_n_q;
    logic irq_weak_q;
    logic [1:0] vp_now;
    logic [1:0] vp_prev;
    logic [FLG_DRV_HI-FLG_DRV_LO:0] drv_now;
    logic [FLG_DRV_HI-FLG_DRV_LO:0] drv_prev;

    sei_spi_link u_link (
        .spi_sck(SPI_SCK),
        .spi_cs_n(SPI_CS_N),
        .spi_sdi(SPI_SDI),
        .sys_rst(SYS_RST),
        .tx_word(tx_q),
        .rx_word(rx_word),
        .rx_toggle(rx_toggle),
        .sdo(SPI_SDO),
        .sdo_oe_n(SPI_SDO_OE_N)
    );

    // Frame toggle and chip select cross into the core clock
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_seen_q <= 1'b0;
            csn_s1_q <= 1'b1;
            csn_s2_q <= 1'b1;
        end else begin
            tgl_s1_q <= rx_toggle;
            tgl_s2_q <= tgl_s1_q;
            tgl_seen_q <= tgl_s2_q;
            csn_s1_q <= SPI_CS_N;
            csn_s2_q <= csn_s1_q;
        end
    end

    assign frame_ev = tgl_s2_q ^ tgl_seen_q;
    assign is_wr = rx_word[FRM_WR];
    assign addr = rx_word[FRM_ADR_HI:FRM_ADR_LO];
    assign rx_data = rx_word[FRM_DAT_HI:0];

    // Configuration registers written by the host
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            gcfg_q <= GCFG_RST;
            sel_q <= SEL_RST;
            prot_q <= PROT_RST;
            ien_q <= IEN_RST;
        end else if (frame_ev && is_wr) begin
            case (addr)
                ADR_GCFG: gcfg_q <= rx_data;
                ADR_SEL: sel_q <= rx_data;
                ADR_PROT: prot_q <= rx_data;
                ADR_IEN: ien_q <= rx_data;
                default: ;
            endcase
        end
    end

    // Flags come from logic on this clock, so edges are taken without a synchroniser
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            flags_prev_q <= COND_FLAGS;
        end else begin
            flags_prev_q <= COND_FLAGS;
        end
    end

    assign vp_now = COND_FLAGS[FLG_VP_HI:FLG_VP_LO];
    assign vp_prev = flags_prev_q[FLG_VP_HI:FLG_VP_LO];
    assign drv_now = COND_FLAGS[FLG_DRV_HI:FLG_DRV_LO];
    assign drv_prev = flags_prev_q[FLG_DRV_HI:FLG_DRV_LO];

    always_comb begin
        trig = '0;
        trig[EV_REPLY] = DRV_REPLY_READY;
        trig[EV_DRV] = |(drv_now & ~drv_prev);
        trig[EV_VP00] = (vp_now == VP_00) && (vp_prev != VP_00);
        trig[EV_VP01] = (vp_now == VP_01) && (vp_prev != VP_01);
        trig[EV_VP10] = (vp_now == VP_10) && (vp_prev != VP_10);
        trig[EV_GEN_HI:EV_GEN_LO] = COND_FLAGS[FLG_GEN_HI:FLG_GEN_LO]
            & ~flags_prev_q[FLG_GEN_HI:FLG_GEN_LO];
    end

    // A read clears all but protected bits; a write clears the ones it carries
    always_comb begin
        clr = '0;
        if (frame_ev && (addr == ADR_EV)) begin
            if (is_wr) begin
                clr = rx_data;
            end else begin
                clr = ~prot_q;
            end
        end
    end

    // Set wins over clear so an event in the clearing cycle survives
    assign ev_d = (ev_q & ~clr) | trig;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ev_q <= EV_RST;
        end else begin
            ev_q <= ev_d;
        end
    end

    always_comb begin
        case (addr)
            ADR_GCFG: rd_val = gcfg_q;
            ADR_SEL: rd_val = sel_q;
            ADR_PROT: rd_val = prot_q;
            ADR_IEN: rd_val = ien_q;
            ADR_EV: rd_val = ev_q;
            ADR_FLAGS: rd_val = COND_FLAGS;
            default: rd_val = '0;
        endcase
    end

    // Read data is returned in the following frame, value taken before any clear
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rd_hold_q <= RDH_RST;
        end else if (frame_ev) begin
            rd_hold_q <= rd_val;
        end
    end

    // Response only changes while deselected, so the link never sees it move mid-frame
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            tx_q <= TX_RST;
        end else if (csn_s2_q && !frame_ev) begin
            tx_q <= {sei_pick8(ev_q, sel_q), rd_hold_q};
        end
    end

    assign irq_any = |(ev_q & ien_q);
    assign irq_pol = gcfg_q[GCFG_IRQ_POL];
    assign irq_weak = gcfg_q[GCFG_IRQ_WEAK];
    assign irq_wand = gcfg_q[GCFG_IRQ_WAND];

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            irq_o_q <= 1'b1;
            irq_oe_n_q <= 1'b0;
            irq_weak_q <= 1'b0;
        end else begin
            irq_o_q <= irq_any ~^ irq_pol;
            if (!irq_weak) begin
                irq_oe_n_q <= 1'b0;
                irq_weak_q <= 1'b0;
            end else if (irq_wand) begin
                irq_oe_n_q <= irq_any;
                irq_weak_q <= irq_any;
            end else begin
                irq_oe_n_q <= ~irq_any;
                irq_weak_q <= ~irq_any;
            end
        end
    end

    assign IRQ_O = irq_o_q;
    assign IRQ_OE_N = irq_oe_n_q;
    assign IRQ_WEAK_EN = irq_weak_q;
    assign GLOBAL_CONFIG = gcfg_q;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    property p_flag_sets;
        $rose(COND_FLAGS[FLG_GEN_LO]) |=> ev_q[EV_GEN_LO];
    endproperty
    a_flag_sets: assert property (p_flag_sets)
        else $error("flag rise did not set its event");

    property p_sticky;
        !frame_ev |=> ((ev_q & $past(ev_q)) == $past(ev_q));
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("event dropped without a clear");

    property p_live_read;
        (frame_ev && !is_wr && (addr == ADR_FLAGS)) |=> (rd_hold_q == $past(COND_FLAGS));
    endproperty
    a_live_read: assert property (p_live_read)
        else $error("flag read is not the live condition");

    property p_drv_event;
        (|(drv_now & ~drv_prev)) |=> ev_q[EV_DRV];
    endproperty
    a_drv_event: assert property (p_drv_event)
        else $error("driver fault event missing");

    property p_vp01;
        ((vp_now == VP_01) && (vp_prev != VP_01))
            |=> ev_q[EV_VP01] ##1 (ev_q[EV_VP01] || $past(frame_ev));
    endproperty
    a_vp01: assert property (p_vp01)
        else $error("velocity phase event missing");

    property p_reply;
        DRV_REPLY_READY |=> ev_q[EV_REPLY];
    endproperty
    a_reply: assert property (p_reply)
        else $error("reply event missing");

    property p_read_clear;
        (frame_ev && !is_wr && (addr == ADR_EV) && (trig == '0))
            |=> (ev_q == ($past(ev_q) & $past(prot_q)));
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("event read did not clear as masked");

    property p_protect;
        (frame_ev && !is_wr && (addr == ADR_EV)) |=> ((ev_q & $past(prot_q)) == ($past(ev_q) & $past(prot_q)));
    endproperty
    a_protect: assert property (p_protect)
        else $error("protected event lost on read");

    property p_w1c;
        (frame_ev && is_wr && (addr == ADR_EV) && (trig == '0))
            |=> (ev_q == ($past(ev_q) & ~$past(rx_data)));
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("write one did not clear event");

    property p_status_low;
        (csn_s2_q && !frame_ev && (sel_q[0] == 1'b1)) |=> (tx_q[FRM_ADR_LO] == $past(ev_q[0]));
    endproperty
    a_status_low: assert property (p_status_low)
        else $error("lowest selected event not in status bit 0");

    property p_irq_high;
        (irq_any && irq_pol) |=> IRQ_O;
    endproperty
    a_irq_high: assert property (p_irq_high)
        else $error("enabled event not signalled");

    property p_irq_low;
        (irq_any && !irq_pol) |=> !IRQ_O;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("default polarity not active low");

    property p_wired_or;
        (irq_weak && !irq_wand && !irq_any) |=> (IRQ_OE_N && IRQ_WEAK_EN);
    endproperty
    a_wired_or: assert property (p_wired_or)
        else $error("inactive level not weak in wired-or");

    property p_wired_and;
        (irq_weak && irq_wand && irq_any) |=> (IRQ_OE_N && IRQ_WEAK_EN);
    endproperty
    a_wired_and: assert property (p_wired_and)
        else $error("active level not weak in wired-and");

    property p_strong_drive;
        !irq_weak |=> (!IRQ_OE_N && !IRQ_WEAK_EN);
    endproperty
    a_strong_drive: assert property (p_strong_drive)
        else $error("weak drive used while disabled");

    property p_set_wins;
        (DRV_REPLY_READY && frame_ev && (addr == ADR_EV)) |=> ev_q[EV_REPLY];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost in clearing cycle");

    c_read_clear: cover property (frame_ev && !is_wr && (addr == ADR_EV) && (ev_q != '0));
    c_w1c: cover property (frame_ev && is_wr && (addr == ADR_EV) && ((ev_q & prot_q) != '0));
    c_irq: cover property (irq_any ##1 !irq_any);
    c_many_sel: cover property (csn_s2_q && ($countones(sel_q) > 8));
    c_set_wins: cover property (DRV_REPLY_READY && frame_ev && !is_wr && (addr == ADR_EV));
endmodule : sei_status_event_irq
`default_nettype wire

// File: hw/sei_pkg.sv
`default_nettype none
package sei_pkg;
    localparam int REG_W = 32;
    localparam int SPI_BITS = 40;
    localparam int CNT_W = 6;
    localparam int ADR_W = 7;
    localparam int STAT_BITS = 8;

    // Frame layout: write flag, address, then data, most significant bit first
    localparam int FRM_WR = 39;
    localparam int FRM_ADR_HI = 38;
    localparam int FRM_ADR_LO = 32;
    localparam int FRM_DAT_HI = 31;

    localparam logic [ADR_W-1:0] ADR_GCFG = 7'h00;
    localparam logic [ADR_W-1:0] ADR_SEL = 7'h0B;
    localparam logic [ADR_W-1:0] ADR_PROT = 7'h0C;
    localparam logic [ADR_W-1:0] ADR_IEN = 7'h0D;
    localparam logic [ADR_W-1:0] ADR_EV = 7'h0E;
    localparam logic [ADR_W-1:0] ADR_FLAGS = 7'h0F;

    localparam logic [REG_W-1:0] GCFG_RST = 32'h0000_0000;
    localparam logic [REG_W-1:0] SEL_RST = 32'h0000_0000;
    localparam logic [REG_W-1:0] PROT_RST = 32'h0000_0000;
    localparam logic [REG_W-1:0] IEN_RST = 32'h0000_0000;
    localparam logic [REG_W-1:0] EV_RST = 32'h0000_0000;
    localparam logic [REG_W-1:0] RDH_RST = 32'h0000_0000;
    localparam logic [SPI_BITS-1:0] TX_RST = 40'h00_0000_0000;

    // Interrupt pin controls in global_config
    localparam int GCFG_IRQ_POL = 15;
    localparam int GCFG_IRQ_WEAK = 29;
    localparam int GCFG_IRQ_WAND = 30;

    // Live condition flag layout
    localparam int FLG_VP_LO = 0;
    localparam int FLG_VP_HI = 1;
    localparam int FLG_GEN_LO = 2;
    localparam int FLG_GEN_HI = 23;
    localparam int FLG_DRV_LO = 24;
    localparam int FLG_DRV_HI = 31;

    localparam logic [1:0] VP_00 = 2'h0;
    localparam logic [1:0] VP_01 = 2'h1;
    localparam logic [1:0] VP_10 = 2'h2;

    // Event positions in latched_event_bits
    localparam int EV_REPLY = 0;
    localparam int EV_DRV = 1;
    localparam int EV_VP00 = 2;
    localparam int EV_VP01 = 3;
    localparam int EV_VP10 = 4;
    localparam int EV_GEN_LO = 5;
    localparam int EV_GEN_HI = EV_GEN_LO + FLG_GEN_HI - FLG_GEN_LO;

    // Lowest-indexed selected events fill status bits from bit 0 upward
    function automatic logic [STAT_BITS-1:0] sei_pick8(
        input logic [REG_W-1:0] ev,
        input logic [REG_W-1:0] sel
    );
        logic [STAT_BITS-1:0] res;
        logic [3:0] n;
        res = '0;
        n = '0;
        for (int i = 0; i < REG_W; i++) begin
            if (sel[i] && (n < 4'h8)) begin
                res[n[2:0]] = ev[i];
                n = n + 4'h1;
            end
        end
        return res;
    endfunction : sei_pick8
endpackage : sei_pkg
`default_nettype wire

// File: hw/sei_spi_link.sv
`timescale 1ns/100ps
`default_nettype none
module sei_spi_link (
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    input wire logic sys_rst,
    input wire logic [sei_pkg::SPI_BITS-1:0] tx_word,
    output logic [sei_pkg::SPI_BITS-1:0] rx_word,
    output logic rx_toggle,
    output logic sdo,
    output logic sdo_oe_n
);
    import sei_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic [SPI_BITS-1:0] shift_q;
    logic [SPI_BITS-1:0] rx_q;
    logic tgl_q;
    logic first_q;
    logic oe_n_q;
    logic [SPI_BITS-1:0] out_q;
    logic last_bit;

    assign last_bit = (cnt_q == CNT_W'(SPI_BITS - 1));

    // Chip select high holds the bit counter in reset, so a cut frame never shifts the next one
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            cnt_q <= '0;
        end else if (cnt_q != CNT_W'(SPI_BITS)) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge spi_sck) begin
        shift_q <= {shift_q[SPI_BITS-2:0], spi_sdi};
        if (last_bit) begin
            rx_q <= {shift_q[SPI_BITS-2:0], spi_sdi};
        end
    end

    // Toggle marks each complete frame; rx_q stays put until the next one
    always_ff @(posedge spi_sck or posedge sys_rst) begin
        if (sys_rst) begin
            tgl_q <= 1'b0;
        end else if (last_bit) begin
            tgl_q <= ~tgl_q;
        end
    end

    // First falling edge loads the response; tx_word is held still by the core while selected
    always_ff @(negedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            first_q <= 1'b1;
            oe_n_q <= 1'b1;
            out_q <= TX_RST;
        end else if (first_q) begin
            first_q <= 1'b0;
            oe_n_q <= 1'b0;
            out_q <= tx_word;
        end else begin
            out_q <= {out_q[SPI_BITS-2:0], 1'b0};
        end
    end

    assign rx_word = rx_q;
    assign rx_toggle = tgl_q;
    assign sdo = out_q[SPI_BITS-1];
    assign sdo_oe_n = oe_n_q;
endmodule : sei_spi_link
`default_nettype wire

// File: bench/sei_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sei_host_model (
    output logic SPI_SCK,
    output logic SPI_CS_N,
    output logic SPI_SDI,
    input wire logic SPI_SDO,
    input wire logic SPI_SDO_OE_N
);
    import sei_pkg::*;
    // Chip select rises after time zero so the link's async clear really fires
    initial begin
        SPI_SCK = 1'b1;
        SPI_CS_N = 1'b0;
        SPI_SDI = 1'b0;
        #1;
        SPI_CS_N = 1'b1;
    end
    // Mode 3 frame; the clock stands high outside frames
    task automatic xfer(input logic [SPI_BITS-1:0] tx, output logic [SPI_BITS-1:0] rx);
        rx = '0;
        SPI_CS_N = 1'b0;
        // Odd lead keeps link edges off the core clock edges
        #507;
        for (int i = SPI_BITS - 1; i >= 0; i--) begin
            SPI_SCK = 1'b0;
            SPI_SDI = tx[i];
            #15;
            SPI_SCK = 1'b1;
            // An undriven data line must not pass for a valid bit
            rx[i] = SPI_SDO_OE_N ? 1'bx : SPI_SDO;
            #15;
        end
        SPI_CS_N = 1'b1;
        SPI_SDI = ~SPI_SDI;
        // Gap lets read data and status reach the response register
        #1000;
    endtask : xfer
endmodule : sei_host_model
`default_nettype wire

// File: bench/sei_status_event_irq_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module sei_status_event_irq_tb_top;
    import sei_pkg::*;
    localparam int TIMEOUT_CYC = 20000;
    logic clk;
    logic sys_rst = 1'b0;
    logic spi_sck, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe_n;
    logic [REG_W-1:0] cond_flags = '0;
    logic drv_reply_ready = 1'b0;
    logic irq_o, irq_oe_n, irq_weak_en;
    logic [REG_W-1:0] global_config;
    logic [SPI_BITS-1:0] rx;
    logic [REG_W-1:0] rdat;
    logic [STAT_BITS-1:0] stat;
    logic [ADR_W-1:0] adrs [4] = '{ADR_GCFG, ADR_SEL, ADR_PROT, ADR_IEN};
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;

    sei_status_event_irq sei_status_event_irq_inst (
        .CLK(clk), .SYS_RST(sys_rst), .SPI_SCK(spi_sck), .SPI_CS_N(spi_cs_n),
        .SPI_SDI(spi_sdi), .COND_FLAGS(cond_flags), .DRV_REPLY_READY(drv_reply_ready),
        .SPI_SDO(spi_sdo), .SPI_SDO_OE_N(spi_sdo_oe_n), .IRQ_O(irq_o),
        .IRQ_OE_N(irq_oe_n), .IRQ_WEAK_EN(irq_weak_en), .GLOBAL_CONFIG(global_config)
    );
    sei_host_model sei_host_model_inst (
        .SPI_SCK(spi_sck), .SPI_CS_N(spi_cs_n), .SPI_SDI(spi_sdi),
        .SPI_SDO(spi_sdo), .SPI_SDO_OE_N(spi_sdo_oe_n)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic stop_test();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYC) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic chk(input logic [REG_W-1:0] seen, input logic [REG_W-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [ADR_W-1:0] adr, input logic [REG_W-1:0] d);
        sei_host_model_inst.xfer({1'b1, adr, d}, rx);
    endtask : wr

    // Read data comes back one frame late, so a harmless frame follows
    task automatic rd(input logic [ADR_W-1:0] adr);
        sei_host_model_inst.xfer({1'b0, adr, 32'h0}, rx);
        sei_host_model_inst.xfer({1'b0, ADR_GCFG, 32'h0}, rx);
        rdat = rx[FRM_DAT_HI:0];
        stat = rx[SPI_BITS-1:FRM_ADR_LO];
    endtask : rd

    task automatic rd_chk(input logic [ADR_W-1:0] adr, input logic [REG_W-1:0] exp);
        rd(adr);
        chk(rdat, exp);
    endtask : rd_chk

    task automatic set_flags(input logic [REG_W-1:0] v);
        @(posedge clk);
        cond_flags <= v;
        repeat (3) @(posedge clk);
    endtask : set_flags

    task automatic irq_case(input logic [REG_W-1:0] gc, input logic [REG_W-1:0] ien,
        input logic o, input logic oe_n);
        wr(ADR_GCFG, gc);
        wr(ADR_IEN, ien);
        @(negedge clk);
        chk(REG_W'({irq_oe_n, irq_weak_en, irq_o}), REG_W'({oe_n, oe_n, o}));
        chk(global_config, gc);
    endtask : irq_case

    initial begin
        // Rising reset at time zero also clears the link-side frame toggle
        sys_rst <= 1'b1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(negedge clk);
        chk(REG_W'({irq_oe_n, irq_weak_en, irq_o}), 32'h1);
        rd_chk(ADR_EV, EV_RST);
        for (int i = 0; i < 4; i++) begin
            rd_chk(adrs[i], 32'h0);
            wr(adrs[i], 32'h5A5A_A5A5);
            rd_chk(adrs[i], 32'h5A5A_A5A5);
            wr(adrs[i], 32'h0);
        end
        wr(7'h05, 32'hFFFF_FFFF);
        rd_chk(7'h05, 32'h0);
        // Velocity phase 01, 10, then back to 00; two driver flags at once
        set_flags(32'h0000_0004);
        set_flags(32'h0000_0000);
        set_flags(32'h0500_0000);
        set_flags(32'h0500_0001);
        set_flags(32'h0500_0002);
        set_flags(32'h0500_0000);
        @(posedge clk);
        drv_reply_ready <= 1'b1;
        @(posedge clk);
        drv_reply_ready <= 1'b0;
        wr(ADR_FLAGS, 32'hFFFF_FFFF);
        rd_chk(ADR_FLAGS, 32'h0500_0000);
        wr(ADR_PROT, 32'h0000_0021);
        rd_chk(ADR_EV, 32'h0000_003F);
        rd_chk(ADR_EV, 32'h0000_0021);
        wr(ADR_EV, 32'h0000_0001);
        rd_chk(ADR_EV, 32'h0000_0020);
        wr(ADR_EV, 32'h0000_0020);
        rd_chk(ADR_EV, 32'h0000_0000);
        // Events 5 and 12; the latter lies beyond the eighth selected position
        set_flags(32'h0500_0204);
        wr(ADR_SEL, 32'hFFFF_FFF0);
        rd(ADR_GCFG);
        chk(REG_W'(stat), 32'h0000_0002);
        wr(ADR_SEL, 32'h0000_1000);
        rd(ADR_GCFG);
        chk(REG_W'(stat), 32'h0000_0001);
        irq_case(32'h0000_0000, 32'h0000_1000, 1'b0, 1'b0);
        irq_case(32'h0000_0000, 32'h0000_0800, 1'b1, 1'b0);
        irq_case(32'h0000_8000, 32'h0000_1000, 1'b1, 1'b0);
        irq_case(32'h2000_0000, 32'h0000_1000, 1'b0, 1'b0);
        irq_case(32'h2000_0000, 32'h0000_0000, 1'b1, 1'b1);
        irq_case(32'h6000_0000, 32'h0000_1000, 1'b0, 1'b1);
        irq_case(32'h6000_0000, 32'h0000_0000, 1'b1, 1'b0);
        // Reply held through an unprotected read-clear: the set must win
        wr(ADR_PROT, 32'h0);
        @(posedge clk);
        drv_reply_ready <= 1'b1;
        rd_chk(ADR_EV, 32'h0000_1021);
        rd_chk(ADR_EV, 32'h0000_0001);
        @(posedge clk);
        drv_reply_ready <= 1'b0;
        rd_chk(ADR_EV, 32'h0000_0001);
        rd_chk(ADR_EV, 32'h0000_0000);
        stop_test();
    end
endmodule : sei_status_event_irq_tb_top
`default_nettype wire
